// ### tcp_timer.sv
// Timer with prescaler, capture/compare and PWM output, register-configured
`timescale 1ns/10ps
module tcp_timer
    import tcp_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ext_count_clock_pin,
    input wire logic capture_one_pin,
    input wire logic capture_two_pin,
    output logic timer_wave_pin_o,
    output logic timer_wave_pin_oe,
    output logic irq
);
    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [3:0] count_prescale_select_q;
    logic [7:0] timer_mode_cfg_q;
    logic [6:0] capture_edge_cfg_q;
    logic [CNT_W-1:0] compare_one_value_q;
    logic [CNT_W-1:0] compare_two_value_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] cap1_q;
    logic [CNT_W-1:0] cap2_q;
    logic [14:0] pre_q;
    logic [TCP_NSTAT-1:0] status_q;
    logic [TCP_NSTAT-1:0] mask_q;
    logic wave_q;
    logic [7:0] rdata_q;
    logic irq_q;
    logic oe_q;

    logic wr_ps, wr_mode, wr_edge, wr_status;
    logic run, cap_mode, ext_en;
    logic ext_hit, cap1_raw, cap2_raw, cap2_src;
    logic cap1_ev, cap2_ev, tick, ovf_ev, cmp1_ev, cmp2_ev, cc2_ev;
    logic [1:0] ext_sel;
    logic [TCP_NSTAT-1:0] set_ev;
    tcp_force_t force_cmd;

    // Byte access for values up to 16 bits; a short value reads zero above
    function automatic logic [CNT_W-1:0] put_byte(input logic [CNT_W-1:0] v,
            input logic hi, input logic [7:0] b);
        logic [15:0] r;
        r = 16'(v);
        if (hi) begin
            r[15:8] = b;
        end else begin
            r[7:0] = b;
        end
        return CNT_W'(r);
    endfunction

    function automatic logic [7:0] get_byte(input logic [CNT_W-1:0] v, input logic hi);
        logic [15:0] w;
        w = 16'(v);
        return hi ? w[15:8] : w[7:0];
    endfunction

    assign wr_ps = reg_wr && reg_addr == TCP_ADDR_PRESCALE;
    assign wr_mode = reg_wr && reg_addr == TCP_ADDR_MODE;
    assign wr_edge = reg_wr && reg_addr == TCP_ADDR_EDGE;
    assign wr_status = reg_rd && reg_addr == TCP_ADDR_STATUS;

    // -------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_prescale_select_q <= TCP_RST_BYTE[3:0];
            timer_mode_cfg_q <= TCP_RST_BYTE;
            capture_edge_cfg_q <= TCP_RST_BYTE[6:0];
            mask_q <= TCP_RST_BYTE[TCP_NSTAT-1:0];
            compare_one_value_q <= '0;
            compare_two_value_q <= '0;
        end else begin
            if (wr_ps) begin
                count_prescale_select_q <= reg_wdata[TCP_PS_MSB:0];
            end
            if (wr_mode) begin
                timer_mode_cfg_q <= reg_wdata;
            end
            if (wr_edge) begin
                // Strobe bits 6 and 5 are not stored
                capture_edge_cfg_q <= {2'b00, reg_wdata[TCP_B_TIE:0]};
            end
            if (reg_wr && reg_addr == TCP_ADDR_MASK) begin
                mask_q <= reg_wdata[TCP_NSTAT-1:0];
            end
            if (reg_wr && reg_addr == TCP_ADDR_CMP1_LO) begin
                compare_one_value_q <= put_byte(compare_one_value_q, 1'b0, reg_wdata);
            end
            if (reg_wr && reg_addr == TCP_ADDR_CMP1_HI) begin
                compare_one_value_q <= put_byte(compare_one_value_q, 1'b1, reg_wdata);
            end
            if (reg_wr && reg_addr == TCP_ADDR_CMP2_LO) begin
                compare_two_value_q <= put_byte(compare_two_value_q, 1'b0, reg_wdata);
            end
            if (reg_wr && reg_addr == TCP_ADDR_CMP2_HI) begin
                compare_two_value_q <= put_byte(compare_two_value_q, 1'b1, reg_wdata);
            end
        end
    end

    assign run = timer_mode_cfg_q[TCP_B_RUN];
    assign cap_mode = timer_mode_cfg_q[TCP_B_MODE];
    assign ext_en = timer_mode_cfg_q[TCP_B_ECLK];

    // -------------------------------------------------------------------
    // Edge detection
    // -------------------------------------------------------------------
    assign ext_sel = timer_mode_cfg_q[TCP_B_EDGE] ? TCP_EDGE_FALL : TCP_EDGE_RISE;
    assign cap2_src = capture_edge_cfg_q[TCP_B_TIE] ? capture_one_pin
                                                    : capture_two_pin;

    tcp_edge_det u_ext (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sig_in(ext_count_clock_pin),
        .edge_sel(ext_sel),
        .hit(ext_hit)
    );
    tcp_edge_det u_cap1 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sig_in(capture_one_pin),
        .edge_sel(capture_edge_cfg_q[TCP_E1_LSB +: 2]),
        .hit(cap1_raw)
    );
    tcp_edge_det u_cap2 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sig_in(cap2_src),
        .edge_sel(capture_edge_cfg_q[TCP_E2_LSB +: 2]),
        .hit(cap2_raw)
    );

    assign cap1_ev = cap1_raw && timer_mode_cfg_q[TCP_B_CAP1EN];
    assign cap2_ev = cap2_raw && timer_mode_cfg_q[TCP_B_CAP2EN];

    // -------------------------------------------------------------------
    // Prescaler and counter
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
        end else if (!run) begin
            pre_q <= '0;
        end else if (tick || wr_ps) begin
            // New select restarts the division from zero
            pre_q <= '0;
        end else if (ext_en ? ext_hit : 1'b1) begin
            pre_q <= pre_q + 15'h1;
        end
    end

    // Terminal count of 2**select - 1 source edges
    assign tick = run && (ext_en ? ext_hit : 1'b1)
        && pre_q == 15'((16'h1 << count_prescale_select_q) - 16'h1);
    assign ovf_ev = tick && (&count_q);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (cap1_ev && timer_mode_cfg_q[TCP_B_CLRCAP]) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= count_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap1_q <= '0;
            cap2_q <= '0;
        end else begin
            if (cap1_ev) begin
                cap1_q <= count_q;
            end
            if (cap2_ev && cap_mode) begin
                cap2_q <= count_q;
            end
        end
    end

    // -------------------------------------------------------------------
    // Events and interrupt
    // -------------------------------------------------------------------
    assign cmp1_ev = tick && count_q == compare_one_value_q;
    assign cmp2_ev = tick && !cap_mode && count_q == compare_two_value_q;
    assign cc2_ev = cap_mode ? cap2_ev : cmp2_ev;
    assign set_ev = {ovf_ev, cc2_ev, cap1_ev, cmp1_ev};

    // Set wins over the clearing read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '0;
        end else if (wr_status) begin
            status_q <= set_ev;
        end else begin
            status_q <= status_q | set_ev;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |((wr_status ? set_ev : (status_q | set_ev)) & mask_q);
        end
    end

    // -------------------------------------------------------------------
    // Waveform output
    // -------------------------------------------------------------------
    always_comb begin
        if (wr_edge && reg_wdata[TCP_B_FHI]) begin
            force_cmd = TCP_OUT_HIGH;
        end else if (wr_edge && reg_wdata[TCP_B_FLO]) begin
            force_cmd = TCP_OUT_LOW;
        end else begin
            force_cmd = TCP_OUT_HOLD;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_q <= 1'b0;
        end else begin
            case (force_cmd)
                TCP_OUT_HIGH: wave_q <= 1'b1;
                TCP_OUT_LOW: wave_q <= 1'b0;
                default: begin
                    if (!cap_mode && tick && (&count_q)) begin
                        wave_q <= 1'b1;
                    end else if (cmp1_ev && !cap_mode) begin
                        wave_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= wr_mode ? reg_wdata[TCP_B_OEN] : timer_mode_cfg_q[TCP_B_OEN];
        end
    end

    assign timer_wave_pin_o = wave_q;
    assign timer_wave_pin_oe = oe_q;
    assign irq = irq_q;

    // -------------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                TCP_ADDR_PRESCALE: rdata_q <= {4'h0, count_prescale_select_q};
                TCP_ADDR_MODE: rdata_q <= timer_mode_cfg_q;
                TCP_ADDR_EDGE: rdata_q <= {1'b0, capture_edge_cfg_q};
                TCP_ADDR_CMP1_LO: rdata_q <= get_byte(compare_one_value_q, 1'b0);
                TCP_ADDR_CMP1_HI: rdata_q <= get_byte(compare_one_value_q, 1'b1);
                TCP_ADDR_CMP2_LO: rdata_q <= get_byte(compare_two_value_q, 1'b0);
                TCP_ADDR_CMP2_HI: rdata_q <= get_byte(compare_two_value_q, 1'b1);
                TCP_ADDR_CNT_LO: rdata_q <= get_byte(count_q, 1'b0);
                TCP_ADDR_CNT_HI: rdata_q <= get_byte(count_q, 1'b1);
                TCP_ADDR_CAP1_LO: rdata_q <= get_byte(cap1_q, 1'b0);
                TCP_ADDR_CAP1_HI: rdata_q <= get_byte(cap1_q, 1'b1);
                TCP_ADDR_CAP2_LO: rdata_q <= get_byte(cap2_q, 1'b0);
                TCP_ADDR_CAP2_HI: rdata_q <= get_byte(cap2_q, 1'b1);
                TCP_ADDR_STATUS: rdata_q <= {4'h0, status_q};
                TCP_ADDR_MASK: rdata_q <= {4'h0, mask_q};
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    sequence s_force_hi;
        wr_edge && reg_wdata[TCP_B_FHI];
    endsequence

    chk_force_high_out: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_force_hi |=> timer_wave_pin_o)
        else $error("force high did not drive output");
    chk_force_low_out: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_edge && !reg_wdata[TCP_B_FHI] && reg_wdata[TCP_B_FLO] |=> !timer_wave_pin_o)
        else $error("force low did not drive output");
    chk_strobe_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == TCP_ADDR_EDGE |=> reg_rdata[TCP_B_FHI:TCP_B_FLO] == 2'b00)
        else $error("force strobes read nonzero");
    chk_prescale_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == TCP_ADDR_PRESCALE |=> reg_rdata[7:4] == 4'h0)
        else $error("prescale upper bits nonzero");
    chk_stopped_count_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !run && !(cap1_ev && timer_mode_cfg_q[TCP_B_CLRCAP]) |=> $stable(count_q))
        else $error("count moved while stopped");
    chk_clear_on_cap: assert property (@(posedge core_clk) disable iff (!rst_n)
        cap1_ev && timer_mode_cfg_q[TCP_B_CLRCAP] |=> count_q == '0)
        else $error("count not cleared on capture");
    chk_overflow_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        status_q[TCP_S_OVF] && !wr_status |=> status_q[TCP_S_OVF])
        else $error("overflow flag lost");
    chk_cap1_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        !timer_mode_cfg_q[TCP_B_CAP1EN] |-> !cap1_ev)
        else $error("capture one while disabled");
    chk_cap2_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        cap_mode && cap2_ev |=> status_q[TCP_S_CC2])
        else $error("capture two flag not set");
    chk_oe_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_mode |=> timer_wave_pin_oe == $past(reg_wdata[TCP_B_OEN]))
        else $error("output enable wrong");
    chk_ext_count_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        run && ext_en && !ext_hit
        && !(cap1_ev && timer_mode_cfg_q[TCP_B_CLRCAP])
        |=> $stable(count_q))
        else $error("count moved without external edge");
    chk_cmp2_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmp2_ev |=> status_q[TCP_S_CC2])
        else $error("compare two flag not set");
    chk_ovf_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        ovf_ev |=> status_q[TCP_S_OVF])
        else $error("overflow flag not set");
    chk_cap1_value_taken: assert property (@(posedge core_clk) disable iff (!rst_n)
        cap1_ev |=> cap1_q == $past(count_q))
        else $error("capture one value wrong");
endmodule

// ### tcp_pkg.sv
// Package of constants for the timer capture/PWM configuration block
// Function
// - Prescaler divides count clock by two to the power of the 4-bit select.
// - Mode bit 7 selects PWM/timer at 0, capture/compare at 1.
// - Output enable bit 6 drives the waveform pin; software sets pin direction output.
// - External clock enable bit 5 counts on the external pin instead.
// - Edge select bit 2 picks rising at 0, falling at 1; ignored when disabled.
// - Capture one enable bit 3 gates the first capture pin.
// - Clear-on-capture bit 1 clears the count on each capture-1 event.
// - Run enable bit 0 stops the timer and gates its clock when low.
// - Writing 1 to force-high drives the output high; 0 does nothing.
// - Writing 1 to force-low drives the output low unless force-high is also 1, which wins; 0 does nothing.
// - Force strobes hold no state and read as zero.
// - Tie bit feeds capture-2 input from the first capture pin.
// - Capture-2 edge select: 00 falling, 01 rising, 1x either edge.
// - Capture-1 edge select: 00 falling, 01 rising, 1x either edge.
// - In capture mode, capture-2 edge sets the capture-2 flag.
// - In PWM mode, count equal to compare-2 value sets compare-2 flag.
// - Overflow sets a sticky flag held until software clears it.
package tcp_pkg;
    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam logic [3:0] TCP_ADDR_PRESCALE = 4'h0;
    localparam logic [3:0] TCP_ADDR_MODE = 4'h1;
    localparam logic [3:0] TCP_ADDR_EDGE = 4'h2;
    localparam logic [3:0] TCP_ADDR_CMP1_LO = 4'h3;
    localparam logic [3:0] TCP_ADDR_CMP1_HI = 4'h4;
    localparam logic [3:0] TCP_ADDR_CMP2_LO = 4'h5;
    localparam logic [3:0] TCP_ADDR_CMP2_HI = 4'h6;
    localparam logic [3:0] TCP_ADDR_CNT_LO = 4'h7;
    localparam logic [3:0] TCP_ADDR_CNT_HI = 4'h8;
    localparam logic [3:0] TCP_ADDR_CAP1_LO = 4'h9;
    localparam logic [3:0] TCP_ADDR_CAP1_HI = 4'ha;
    localparam logic [3:0] TCP_ADDR_CAP2_LO = 4'hb;
    localparam logic [3:0] TCP_ADDR_CAP2_HI = 4'hc;
    localparam logic [3:0] TCP_ADDR_STATUS = 4'hd;
    localparam logic [3:0] TCP_ADDR_MASK = 4'he;
    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int TCP_PS_MSB = 3;
    localparam int TCP_B_MODE = 7;
    localparam int TCP_B_OEN = 6;
    localparam int TCP_B_ECLK = 5;
    localparam int TCP_B_CAP2EN = 4;
    localparam int TCP_B_CAP1EN = 3;
    localparam int TCP_B_EDGE = 2;
    localparam int TCP_B_CLRCAP = 1;
    localparam int TCP_B_RUN = 0;
    localparam int TCP_B_FHI = 6;
    localparam int TCP_B_FLO = 5;
    localparam int TCP_B_TIE = 4;
    localparam int TCP_E2_LSB = 2;
    localparam int TCP_E1_LSB = 0;
    // Status bits
    localparam int TCP_S_CMP1 = 0;
    localparam int TCP_S_CAP1 = 1;
    localparam int TCP_S_CC2 = 2;
    localparam int TCP_S_OVF = 3;
    localparam int TCP_NSTAT = 4;
    // -------------------------------------------------------------------
    // Reset values and edge codes
    // -------------------------------------------------------------------
    localparam logic [7:0] TCP_RST_BYTE = 8'h00;
    localparam logic [1:0] TCP_EDGE_FALL = 2'h0;
    localparam logic [1:0] TCP_EDGE_RISE = 2'h1;
    typedef enum logic [1:0] {
        TCP_OUT_HOLD = 2'b00,
        TCP_OUT_HIGH = 2'b01,
        TCP_OUT_LOW = 2'b10
    } tcp_force_t;
endpackage

// ### tcp_edge_det.sv
// Selectable edge detector for one capture or clock input
`timescale 1ns/10ps
module tcp_edge_det
    import tcp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sig_in,
    input wire logic [1:0] edge_sel,
    output logic hit
);
    logic prev_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sig_in;
        end
    end

    // Falling, rising, or either edge for the two upper codes
    always_comb begin
        case (edge_sel)
            TCP_EDGE_FALL: hit = prev_q & ~sig_in;
            TCP_EDGE_RISE: hit = ~prev_q & sig_in;
            default: hit = prev_q ^ sig_in;
        endcase
    end
endmodule

// ### tcp_pin_model.sv
// Model of the pins around the timer: clock source, capture inputs, waveform pin
`timescale 1ns/10ps
module tcp_pin_model (
    input wire logic core_clk,
    input wire logic wave_o,
    input wire logic wave_oe,
    output logic ext_clk,
    output logic cap_one,
    output logic cap_two,
    output logic wave_level
);
    // Pin order: 0 external clock, 1 first capture, 2 second capture
    logic [2:0] pins_q = 3'h0;
    // Software has set the waveform pin as output
    logic port_dir_q = 1'b1;
    assign {cap_two, cap_one, ext_clk} = pins_q;
    // Pull-up holds the pin high when nobody drives it
    assign wave_level = (wave_oe && port_dir_q) ? wave_o : 1'b1;
    task automatic set_pin(input int idx, input logic val);
        @(posedge core_clk);
        pins_q[idx] <= val;
    endtask
endmodule

// ### tcp_timer_tb.sv
// Self-checking testbench of the timer configuration block
`timescale 1ns/10ps
module tcp_timer_tb;
    import tcp_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic wave_o, wave_oe, irq, ext_clk, cap_one, cap_two, wave_level;
    logic [7:0] a;
    int err_count = 0;
    int checked = 0;
    int pss[4] = '{0, 1, 3, 6};
    tcp_timer #(.CNT_W(8)) uut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .ext_count_clock_pin(ext_clk),
        .capture_one_pin(cap_one),
        .capture_two_pin(cap_two),
        .timer_wave_pin_o(wave_o),
        .timer_wave_pin_oe(wave_oe),
        .irq(irq)
    );
    tcp_pin_model pm (
        .core_clk(core_clk),
        .wave_o(wave_o),
        .wave_oe(wave_oe),
        .ext_clk(ext_clk),
        .cap_one(cap_one),
        .cap_two(cap_two),
        .wave_level(wave_level)
    );
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // ---------------------------------------------------------------
    // Bus tasks and comparisons
    // ---------------------------------------------------------------
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_rd(input string nm, input logic [3:0] ad, input logic [7:0] m,
                          input logic [7:0] exp);
        logic [7:0] v;
        rd(ad, v);
        chk(nm, exp, v & m);
    endtask
    // Pin change, then status read which also clears it
    task automatic pin_ev(input string nm, input int idx, input logic val,
                          input logic [7:0] m, input logic e);
        pm.set_pin(idx, val);
        idle(6);
        chk_rd(nm, TCP_ADDR_STATUS, m, e ? m : 8'h00);
    endtask
    // Count advance between two reads taken n+2 cycles apart
    task automatic delta(input string nm, input int n, input logic [7:0] exp);
        logic [7:0] c0, c1;
        rd(TCP_ADDR_CNT_LO, c0);
        idle(n);
        rd(TCP_ADDR_CNT_LO, c1);
        chk(nm, exp, c1 - c0);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        end_sim;
    end
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) chk_rd("reset value", 4'(i), 8'hff, 8'h00);
        wr(4'hf, 8'hff);
        chk_rd("unmapped", 4'hf, 8'hff, 8'h00);
        wr(TCP_ADDR_PRESCALE, 8'hff);
        chk_rd("prescale upper", TCP_ADDR_PRESCALE, 8'hff, 8'h0f);
        // Force strobes with output enabled and timer stopped
        wr(TCP_ADDR_MODE, 8'h40);
        chk_rd("mode reg", TCP_ADDR_MODE, 8'hff, 8'h40);
        wr(TCP_ADDR_EDGE, 8'h40);
        idle(2);
        chk("force high", 8'h01, {7'h00, wave_o});
        chk("out enable", 8'h01, {7'h00, wave_oe});
        wr(TCP_ADDR_EDGE, 8'h00);
        idle(2);
        chk("force zero write", 8'h01, {7'h00, wave_o});
        wr(TCP_ADDR_EDGE, 8'h20);
        idle(2);
        chk("force low", 8'h00, {7'h00, wave_o});
        chk("pin level", 8'h00, {7'h00, wave_level});
        wr(TCP_ADDR_EDGE, 8'h7f);
        chk_rd("strobe readback", TCP_ADDR_EDGE, 8'hff, 8'h1f);
        wr(TCP_ADDR_MODE, 8'h00);
        idle(2);
        chk("out disabled", 8'h00, {7'h00, wave_oe});
        wr(TCP_ADDR_EDGE, 8'h00);
        wr(TCP_ADDR_PRESCALE, 8'h00);
        delta("stopped count", 62, 8'h00);
        wr(TCP_ADDR_MODE, 8'h01);
        foreach (pss[i]) begin
            wr(TCP_ADDR_PRESCALE, 8'(pss[i]));
            idle(4);
            delta("prescale rate", 62, 8'(64 >> pss[i]));
        end
        wr(TCP_ADDR_PRESCALE, 8'h00);
        for (int e = 0; e < 2; e++) begin
            wr(TCP_ADDR_MODE, e ? 8'h25 : 8'h21);
            rd(TCP_ADDR_CNT_LO, a);
            pm.set_pin(0, 1'b1);
            idle(6);
            chk_rd("ext rise", TCP_ADDR_CNT_LO, 8'hff, a + 8'(e == 0));
            pm.set_pin(0, 1'b0);
            idle(6);
            chk_rd("ext fall", TCP_ADDR_CNT_LO, 8'hff, a + 8'h01);
        end
        // Clear on capture with a frozen external count
        wr(TCP_ADDR_MODE, 8'ha9);
        wr(TCP_ADDR_EDGE, 8'h01);
        for (int k = 0; k < 3; k++) begin
            pm.set_pin(0, 1'b1);
            pm.set_pin(0, 1'b0);
        end
        idle(6);
        rd(TCP_ADDR_CNT_LO, a);
        pm.set_pin(1, 1'b1);
        idle(6);
        chk_rd("count kept", TCP_ADDR_CNT_LO, 8'hff, a);
        chk_rd("capture value", TCP_ADDR_CAP1_LO, 8'hff, a);
        pm.set_pin(1, 1'b0);
        wr(TCP_ADDR_MODE, 8'hab);
        pm.set_pin(1, 1'b1);
        idle(6);
        chk_rd("count cleared", TCP_ADDR_CNT_LO, 8'hff, 8'h00);
        pm.set_pin(1, 1'b0);
        // Edge selects of both capture inputs
        wr(TCP_ADDR_MODE, 8'h99);
        for (int t = 1; t < 3; t++) begin
            for (int c = 0; c < 4; c++) begin
                wr(TCP_ADDR_EDGE, t == 1 ? 8'(c) : 8'(c << 2));
                rd(TCP_ADDR_STATUS, a);
                pin_ev("capture rise", t, 1'b1, 8'(t * 2), c != 0);
                pin_ev("capture fall", t, 1'b0, 8'(t * 2), c != 1);
            end
        end
        wr(TCP_ADDR_MODE, 8'h91);
        wr(TCP_ADDR_EDGE, 8'h02);
        pin_ev("cap1 disabled", 1, 1'b1, 8'h02, 1'b0);
        pin_ev("cap1 disabled", 1, 1'b0, 8'h02, 1'b0);
        wr(TCP_ADDR_MODE, 8'h89);
        wr(TCP_ADDR_EDGE, 8'h08);
        pin_ev("cap2 disabled", 2, 1'b1, 8'h04, 1'b0);
        pin_ev("cap2 disabled", 2, 1'b0, 8'h04, 1'b0);
        wr(TCP_ADDR_MODE, 8'h91);
        wr(TCP_ADDR_EDGE, 8'h18);
        pin_ev("tied own pin", 2, 1'b1, 8'h04, 1'b0);
        pin_ev("tied own pin", 2, 1'b0, 8'h04, 1'b0);
        pin_ev("tied first pin", 1, 1'b1, 8'h04, 1'b1);
        pin_ev("tied first pin", 1, 1'b0, 8'h04, 1'b1);
        // PWM compare, overflow and the interrupt line
        wr(TCP_ADDR_EDGE, 8'h00);
        wr(TCP_ADDR_CMP2_LO, 8'h20);
        wr(TCP_ADDR_CMP2_HI, 8'h00);
        wr(TCP_ADDR_MASK, 8'h08);
        wr(TCP_ADDR_MODE, 8'h01);
        rd(TCP_ADDR_STATUS, a);
        idle(300);
        wr(TCP_ADDR_MODE, 8'h00);
        idle(20);
        chk("irq raised", 8'h01, {7'h00, irq});
        wr(TCP_ADDR_MASK, 8'h00);
        idle(2);
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(TCP_ADDR_MASK, 8'h08);
        idle(2);
        chk("irq unmasked", 8'h01, {7'h00, irq});
        chk_rd("cmp2 and ovf", TCP_ADDR_STATUS, 8'h0c, 8'h0c);
        idle(2);
        chk("irq cleared", 8'h00, {7'h00, irq});
        chk_rd("status cleared", TCP_ADDR_STATUS, 8'h0f, 8'h00);
        end_sim;
    end
endmodule
